// ### logic/dma_defines.vh
// register map, field positions and encodings of the two-channel dma
// included by both design files; holds definitions only
`ifndef DMA_DEFINES_VH
`define DMA_DEFINES_VH

`define REG_CTRL 6'h00
`define REG_STAT 6'h04
`define REG_SRC 6'h08
`define REG_DST 6'h0C
`define REG_CNT 6'h10
`define REG_FC 6'h14
`define ADDR_CH_BIT 6
`define ADDR_HOLE_BIT 7

`define CTRL_GO 0
`define CTRL_REQ 2:1
`define CTRL_ECO 3
`define CTRL_SINGLE 4
`define CTRL_SSZ 6:5
`define CTRL_DSZ 8:7
`define CTRL_SSTEP 9
`define CTRL_DSTEP 10
`define CTRL_RST 11'h000

`define REQ_INT 2'h0
`define REQ_BURST 2'h2
`define REQ_STEAL 2'h3

`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1

`define ST_DONE 0
`define ST_BES 1
`define ST_BED 2
`define ST_CONF 3
`define ST_BUSY 7
`define STAT_RST 8'h00

`define DUAL_PORT_BYTES 3'h2
`define SINGLE_PORT_BYTES 3'h4
`define FC_RST 8'h00

`endif

// ### logic/request_sync.v
// pin conditioning for one channel: request and done inputs
// assumes asynchronous pins; outputs are in the clk domain
`timescale 1ns/100ps
`include "dma_defines.vh"

module request_sync (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire request_n_pin,
    input wire done_n_pin,
    output wire request_level,
    output wire request_fall,
    output wire done_seen
);
    reg [2:0] req_q;
    reg [1:0] done_q;

    always @(posedge clk) begin
        if (!rst_n) begin
            req_q <= 3'h7;
            done_q <= 2'h3;
        end else if (ce) begin
            req_q <= {req_q[1:0], request_n_pin};
            done_q <= {done_q[0], done_n_pin};
        end
    end

    // only stages 1 and 2 are looked at; stage 0 may be metastable
    assign request_level = ~req_q[1];
    assign request_fall = req_q[2] & ~req_q[1];
    assign done_seen = ~done_q[1];
endmodule // request_sync

// ### logic/dma_two_channel.v
// two-channel dma: avalon register slave, request handshake, bus engine
// assumes bus_grant, bus_ack, bus_berr and bus_rdata come from clk logic
`timescale 1ns/100ps
`include "dma_defines.vh"

// Operation
// - two independent channels; byte, word, long operands; single or dual address.
// - per channel 32-bit source and destination pointers, each incrementing or fixed, 32-bit count.
// - dual address moves 16 bits per bus cycle; single address moves 32.
// - dual address packs and unpacks differing operand sizes over several bus cycles.
// - register accesses complete in two clock cycles.
// - request seen as low level or falling edge per mode; peripheral drives it.
// - acknowledge asserted only for an external request, during each access on the side that side select picks.
// - done is active-low, two-way, marks the final transfer of the block.
// - reset aborts bus cycle, restores control bits, drops and ignores requests.
// - once started, one operand per recognised request until block end or error.
// - single read ignores destination pointer; single write ignores source pointer.
// - incrementing pointer steps by 1, 2 or 4 per operand; fixed one stays.
// - pointers still advance when a bus error ends the transfer.
// - count drops by the larger operand size per transfer; several cycles possible.
// - function codes: source code on source cycles, destination code on destination cycles.
// - go bit starts channel, except internal single address, which sets the config flag; internal requests bus at once, external waits.
// - control selects internal or external request, and source or destination side.
// - burst request is level sensitive, sampled during the current bus cycle.
// - burst: request still asserted at cycle end gives another transfer, else release.
// - cycle steal: falling edges before acknowledge of a pending request are ignored.
// - cycle steal: request during acknowledge served before release, else bus released.
// - count reaching zero without error sets done flag; done signal driven only for an external request, during each acknowledged access of the last transfer.
// - single address: side select set acknowledges source reads, clear destination writes.
// - channels request the bus by request and grant; fixed priority between them.
module dma_two_channel (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output wire [31:0] avs_readdata,
    output wire avs_waitrequest,
    output wire bus_request,
    input wire bus_grant,
    output wire [31:0] bus_addr,
    output wire bus_rd,
    output wire bus_wr,
    output wire [2:0] bus_size,
    output wire [3:0] bus_fc,
    output wire [31:0] bus_wdata,
    input wire [31:0] bus_rdata,
    input wire bus_ack,
    input wire bus_berr,
    input wire [1:0] transfer_request_n,
    output wire [1:0] transfer_ack_n,
    input wire [1:0] last_transfer_n_in,
    output wire [1:0] last_transfer_n_out,
    output wire [1:0] last_transfer_n_oe
);
    localparam E_IDLE = 5'b00001;
    localparam E_ARB = 5'b00010;
    localparam E_NEXT = 5'b00100;
    localparam E_RD = 5'b01000;
    localparam E_WR = 5'b10000;

    function [2:0] sz_bytes;
        input [1:0] s;
        begin
            case (s)
                `SZ_BYTE: sz_bytes = 3'h1;
                `SZ_WORD: sz_bytes = 3'h2;
                default: sz_bytes = 3'h4;
            endcase
        end
    endfunction

    function [31:0] lane_mask;
        input [2:0] n;
        begin
            case (n)
                3'h1: lane_mask = 32'h0000_00FF;
                3'h2: lane_mask = 32'h0000_FFFF;
                default: lane_mask = 32'hFFFF_FFFF;
            endcase
        end
    endfunction

    reg [10:0] ctrl_q [0:1];
    reg [7:0] stat_q [0:1];
    reg [31:0] src_q [0:1];
    reg [31:0] dst_q [0:1];
    reg [31:0] cnt_q [0:1];
    reg [7:0] fc_q [0:1];
    reg [1:0] pend_q;
    reg [1:0] ack_q;
    reg [1:0] drv_q;
    reg [4:0] st_q;
    reg own_q;
    reg ext_stop_q;
    reg [2:0] rcnt_q;
    reg [2:0] wcnt_q;
    reg [2:0] soff_q;
    reg [2:0] doff_q;
    reg [31:0] hold_q;
    reg bus_req_q;
    reg [31:0] addr_q;
    reg rd_q;
    reg wr_q;
    reg [2:0] size_q;
    reg [3:0] fcode_q;
    reg [31:0] wdata_q;
    reg acc_q;
    reg [31:0] rdata_q;
    reg [31:0] rd_mux;
    reg [7:0] ev_set [0:1];
    reg [7:0] sw_clr [0:1];
    reg [1:0] want;
    integer i;

    wire [1:0] req_lvl;
    wire [1:0] req_fall;
    wire [1:0] done_in;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : gen_pin
            request_sync u_sync (
                .clk(clk),
                .rst_n(rst_n),
                .ce(ce),
                .request_n_pin(transfer_request_n[g]),
                .done_n_pin(last_transfer_n_in[g]),
                .request_level(req_lvl[g]),
                .request_fall(req_fall[g]),
                .done_seen(done_in[g])
            );
        end
    endgenerate

    // register slave: first cycle stalls, second commits
    wire avs_req = avs_read | avs_write;
    wire commit = acc_q & avs_req;
    wire hole = avs_address[`ADDR_HOLE_BIT];
    wire sel_ch = avs_address[`ADDR_CH_BIT];
    wire sw_wr = commit & avs_write & ~hole;
    wire [5:0] sw_off = avs_address[5:0];
    assign avs_waitrequest = avs_req & ~acc_q;
    assign avs_readdata = rdata_q;

    always @* begin
        rd_mux = 32'h0000_0000;
        if (!hole) begin
            case (sw_off)
                `REG_CTRL: rd_mux = {21'h00_0000, ctrl_q[sel_ch]};
                `REG_STAT: begin
                    rd_mux = {24'h00_0000, stat_q[sel_ch]};
                    rd_mux[`ST_BUSY] = (st_q != E_IDLE) & (own_q == sel_ch);
                end
                `REG_SRC: rd_mux = src_q[sel_ch];
                `REG_DST: rd_mux = dst_q[sel_ch];
                `REG_CNT: rd_mux = cnt_q[sel_ch];
                `REG_FC: rd_mux = {24'h00_0000, fc_q[sel_ch]};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            acc_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (ce) begin
            acc_q <= avs_req & ~acc_q;
            if (avs_read & ~acc_q)
                rdata_q <= rd_mux;
        end
    end

    // decode of the channel that owns the engine
    wire [10:0] oc = ctrl_q[own_q];
    wire o_single = oc[`CTRL_SINGLE];
    wire o_eco = oc[`CTRL_ECO];
    wire o_ext = oc[`CTRL_REQ] != `REQ_INT;
    wire [2:0] sb = sz_bytes(oc[`CTRL_SSZ]);
    wire [2:0] db = sz_bytes(oc[`CTRL_DSZ]);
    wire [2:0] ub = (sb > db) ? sb : db;
    wire [2:0] port = o_single ? `SINGLE_PORT_BYTES : `DUAL_PORT_BYTES;
    wire [2:0] rn = (sb > port) ? port : sb;
    wire [2:0] wn = (db > port) ? port : db;
    wire rd_need = ~o_single | o_eco;
    wire wr_need = ~o_single | ~o_eco;
    wire in_next = st_q == E_NEXT;
    wire rd_go = in_next & rd_need & (rcnt_q != ub);
    wire wr_go = in_next & ~rd_go & wr_need & (wcnt_q != ub);
    wire fin = in_next & ~rd_go & ~wr_go;
    wire ack_launch = o_ext & ((rd_go & o_eco) | (wr_go & ~o_eco));
    wire last_op = cnt_q[own_q] <= {29'h0, ub};
    wire [31:0] new_cnt = last_op ? 32'h0000_0000 : cnt_q[own_q] - {29'h0, ub};
    wire [2:0] soff_n = soff_q + rn;
    wire [2:0] doff_n = doff_q + wn;
    wire [2:0] wsh = ub - wcnt_q - wn;
    wire [31:0] src_step = oc[`CTRL_SSTEP] ? {29'h0, sb} : 32'h0000_0000;
    wire [31:0] dst_step = oc[`CTRL_DSTEP] ? {29'h0, db} : 32'h0000_0000;
    wire cycle_end = bus_ack | bus_berr;
    wire cont = ~ext_stop_q & (new_cnt != 32'h0000_0000) & want[own_q];

    // request recognition and status events per channel
    always @* begin
        for (i = 0; i < 2; i = i + 1) begin
            ev_set[i] = 8'h00;
            sw_clr[i] = 8'h00;
            if (sw_wr & (sw_off == `REG_STAT) & (sel_ch == i))
                sw_clr[i] = avs_writedata[7:0];
            ev_set[i][`ST_CONF] = ctrl_q[i][`CTRL_GO] & ctrl_q[i][`CTRL_SINGLE]
                & (ctrl_q[i][`CTRL_REQ] == `REQ_INT);
            case (ctrl_q[i][`CTRL_REQ])
                `REQ_INT: want[i] = 1'b1;
                `REQ_BURST: want[i] = req_lvl[i];
                `REQ_STEAL: want[i] = pend_q[i];
                default: want[i] = 1'b0;
            endcase
            want[i] = want[i] & ctrl_q[i][`CTRL_GO] & ~ev_set[i][`ST_CONF];
        end
        ev_set[own_q][`ST_DONE] = fin & (last_op | ext_stop_q);
        ev_set[own_q][`ST_BES] = (st_q == E_RD) & bus_berr;
        ev_set[own_q][`ST_BED] = (st_q == E_WR) & bus_berr;
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            for (i = 0; i < 2; i = i + 1) begin
                ctrl_q[i] <= `CTRL_RST;
                stat_q[i] <= `STAT_RST;
                src_q[i] <= 32'h0000_0000;
                dst_q[i] <= 32'h0000_0000;
                cnt_q[i] <= 32'h0000_0000;
                fc_q[i] <= `FC_RST;
            end
            pend_q <= 2'b00;
            ack_q <= 2'b00;
            drv_q <= 2'b00;
            st_q <= E_IDLE;
            own_q <= 1'b0;
            ext_stop_q <= 1'b0;
            rcnt_q <= 3'h0;
            wcnt_q <= 3'h0;
            soff_q <= 3'h0;
            doff_q <= 3'h0;
            hold_q <= 32'h0000_0000;
            bus_req_q <= 1'b0;
            addr_q <= 32'h0000_0000;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            size_q <= 3'h0;
            fcode_q <= 4'h0;
            wdata_q <= 32'h0000_0000;
        end else if (ce) begin
            for (i = 0; i < 2; i = i + 1) begin
                // an event in the clearing cycle still lands
                stat_q[i] <= (stat_q[i] & ~sw_clr[i]) | ev_set[i];
                if (ev_set[i] != 8'h00)
                    ctrl_q[i][`CTRL_GO] <= 1'b0;
                if (sw_wr & (sel_ch == i)) begin
                    case (sw_off)
                        `REG_CTRL: ctrl_q[i] <= avs_writedata[10:0];
                        `REG_SRC: src_q[i] <= avs_writedata;
                        `REG_DST: dst_q[i] <= avs_writedata;
                        `REG_CNT: cnt_q[i] <= avs_writedata;
                        `REG_FC: fc_q[i] <= avs_writedata[7:0];
                        default: ;
                    endcase
                end
                // pending edge clears on acknowledge; a new edge wins the tie
                if (!ctrl_q[i][`CTRL_GO])
                    pend_q[i] <= 1'b0;
                else
                    pend_q[i] <= (pend_q[i] & ~(ack_launch & (own_q == i)))
                        | (req_fall[i] & (ctrl_q[i][`CTRL_REQ] == `REQ_STEAL));
            end
            case (st_q)
                E_IDLE: begin
                    bus_req_q <= 1'b0;
                    rcnt_q <= 3'h0;
                    wcnt_q <= 3'h0;
                    soff_q <= 3'h0;
                    doff_q <= 3'h0;
                    ext_stop_q <= 1'b0;
                    if (want[0]) begin
                        own_q <= 1'b0;
                        st_q <= E_ARB;
                    end else if (want[1]) begin
                        own_q <= 1'b1;
                        st_q <= E_ARB;
                    end
                end
                E_ARB: begin
                    bus_req_q <= 1'b1;
                    if (bus_grant)
                        st_q <= E_NEXT;
                end
                E_NEXT: begin
                    if (rd_go) begin
                        addr_q <= src_q[own_q] + {29'h0, soff_q};
                        rd_q <= 1'b1;
                        size_q <= rn;
                        fcode_q <= fc_q[own_q][3:0];
                        st_q <= E_RD;
                    end else if (wr_go) begin
                        addr_q <= dst_q[own_q] + {29'h0, doff_q};
                        wr_q <= 1'b1;
                        size_q <= wn;
                        fcode_q <= fc_q[own_q][7:4];
                        wdata_q <= (hold_q >> {wsh, 3'b000}) & lane_mask(wn);
                        st_q <= E_WR;
                    end else begin
                        cnt_q[own_q] <= new_cnt;
                        rcnt_q <= 3'h0;
                        wcnt_q <= 3'h0;
                        ext_stop_q <= 1'b0;
                        if (!cont) begin
                            bus_req_q <= 1'b0;
                            st_q <= E_IDLE;
                        end
                    end
                    ack_q[own_q] <= ack_launch;
                    drv_q[own_q] <= ack_launch & last_op;
                end
                E_RD, E_WR: begin
                    if (cycle_end) begin
                        rd_q <= 1'b0;
                        wr_q <= 1'b0;
                        ack_q <= 2'b00;
                        drv_q <= 2'b00;
                        if (ack_q[own_q] & ~drv_q[own_q] & done_in[own_q])
                            ext_stop_q <= 1'b1;
                        if (st_q == E_RD) begin
                            soff_q <= (soff_n == sb) ? 3'h0 : soff_n;
                            if (soff_n == sb | bus_berr)
                                src_q[own_q] <= src_q[own_q] + src_step;
                            hold_q <= (hold_q << {rn, 3'b000}) | (bus_rdata & lane_mask(rn));
                            rcnt_q <= rcnt_q + rn;
                        end else begin
                            doff_q <= (doff_n == db) ? 3'h0 : doff_n;
                            if (doff_n == db | bus_berr)
                                dst_q[own_q] <= dst_q[own_q] + dst_step;
                            wcnt_q <= wcnt_q + wn;
                        end
                        if (bus_berr) begin
                            bus_req_q <= 1'b0;
                            st_q <= E_IDLE;
                        end else begin
                            st_q <= E_NEXT;
                        end
                    end
                end
                default: st_q <= E_IDLE;
            endcase
        end
    end

    assign bus_request = bus_req_q;
    assign bus_addr = addr_q;
    assign bus_rd = rd_q;
    assign bus_wr = wr_q;
    assign bus_size = size_q;
    assign bus_fc = fcode_q;
    assign bus_wdata = wdata_q;
    assign transfer_ack_n = ~ack_q;
    // open-drain style: level is always low, the enable decides
    assign last_transfer_n_out = 2'b00;
    assign last_transfer_n_oe = ~drv_q;
endmodule // dma_two_channel

// ### test/dma_two_channel_asserts.sv
// port assertions for the two-channel dma
// bound to every dma_two_channel instance; one clk domain
`timescale 1ns/100ps
module dma_checks (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire bus_request,
    input wire bus_grant,
    input wire bus_rd,
    input wire bus_wr,
    input wire [31:0] bus_addr,
    input wire [2:0] bus_size,
    input wire bus_ack,
    input wire bus_berr,
    input wire [1:0] transfer_ack_n,
    input wire [1:0] last_transfer_n_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence access_s; (avs_read || avs_write) && avs_waitrequest && ce; endsequence
    sequence busy_s; (bus_rd || bus_wr) && !bus_ack && !bus_berr; endsequence
    sequence term_s; (bus_rd || bus_wr) && (bus_ack || bus_berr); endsequence
    access_two_a: assert property (access_s |=> !avs_waitrequest)
        else $error("access over two cycles");
    idle_wait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("stray waitrequest");
    cycle_hold_a: assert property (busy_s |=> (bus_rd || bus_wr) && $stable(bus_addr))
        else $error("bus cycle changed early");
    bus_gap_a: assert property (term_s |=> !bus_rd && !bus_wr)
        else $error("no idle after cycle");
    bus_owner_a: assert property ((bus_rd || bus_wr) |-> bus_request && bus_grant)
        else $error("cycle without grant");
    ack_in_cycle_a: assert property (transfer_ack_n != 2'b11 |-> bus_rd || bus_wr)
        else $error("ack outside cycle");
    ack_single_a: assert property (transfer_ack_n != 2'b00)
        else $error("two acks");
    done_in_cycle_a: assert property (last_transfer_n_oe != 2'b11 |-> bus_rd || bus_wr)
        else $error("done outside cycle");
    size_legal_a: assert property ((bus_rd || bus_wr) |-> bus_size == 3'h1
        || bus_size == 3'h2 || bus_size == 3'h4)
        else $error("illegal bus size");
    reset_quiet_a: assert property ($rose(rst_n) |-> !bus_request && !bus_rd && !bus_wr
        && transfer_ack_n == 2'b11 && last_transfer_n_oe == 2'b11)
        else $error("active after reset");
endmodule // dma_checks
bind dma_two_channel dma_checks i_checks (.clk, .rst_n, .ce, .avs_read, .avs_write,
    .avs_waitrequest, .bus_request, .bus_grant, .bus_rd, .bus_wr, .bus_addr, .bus_size,
    .bus_ack, .bus_berr, .transfer_ack_n, .last_transfer_n_oe);

// ### test/dma_partner.sv
// far side: bus arbiter and memory slave, channel 0 peripheral
// assumes the dma clk domain; operand count loaded by the bench
`timescale 1ns/100ps
module dma_partner (
    input wire clk,
    input wire rst_n,
    input wire bus_request,
    input wire bus_rd,
    input wire bus_wr,
    input wire [31:0] bus_addr,
    input wire [1:0] transfer_ack_n,
    input wire [1:0] last_transfer_n_oe,
    input wire [1:0] slow,
    input wire berr_now,
    input wire steal,
    input wire load,
    input wire [7:0] want,
    output reg bus_grant,
    output reg bus_ack,
    output reg bus_berr,
    output wire [31:0] bus_rdata,
    output wire [1:0] transfer_request_n,
    output wire [1:0] last_transfer_n_in
);
    reg [1:0] wait_q;
    reg [7:0] left_q;
    reg ack_d;
    reg tog_q;
    // released lines toggle, never hold the last value
    assign bus_rdata = bus_rd ? ~bus_addr : {16{tog_q, ~tog_q}};
    assign last_transfer_n_in = last_transfer_n_oe;
    // burst drops request once the last operand is acked
    assign transfer_request_n[0] = steal ? !(left_q != 8'h00 && transfer_ack_n[0] && ack_d)
        : !(left_q > 8'h01 || (left_q == 8'h01 && transfer_ack_n[0]));
    assign transfer_request_n[1] = 1'b1;
    always @(posedge clk) begin
        if (!rst_n) begin
            tog_q <= 1'b0;
            ack_d <= 1'b1;
            left_q <= 8'h00;
            wait_q <= 2'h0;
            bus_grant <= 1'b0;
            bus_ack <= 1'b0;
            bus_berr <= 1'b0;
        end else begin
            tog_q <= ~tog_q;
            ack_d <= transfer_ack_n[0];
            bus_grant <= bus_request;
            bus_ack <= 1'b0;
            bus_berr <= 1'b0;
            if (load)
                left_q <= want;
            else if (transfer_ack_n[0] && !ack_d && left_q != 8'h00)
                left_q <= left_q - 8'h01;
            if ((bus_rd || bus_wr) && !bus_ack && !bus_berr) begin
                wait_q <= wait_q + 2'h1;
                if (wait_q == slow) begin
                    wait_q <= 2'h0;
                    bus_ack <= !berr_now;
                    bus_berr <= berr_now;
                end
            end
        end
    end
endmodule // dma_partner

// ### test/two_channel_dma_request_control_tb.sv
// self-checking bench: registers, internal, burst, steal and single runs
// assumes design, partner and checker compiled first
`timescale 1ns/100ps
`include "dma_defines.vh"
module two_channel_dma_request_control_tb;
    logic clk, rst_n, avs_read, avs_write, avs_waitrequest, bus_request, bus_grant;
    logic bus_rd, bus_wr, bus_ack, bus_berr, berr_now, steal, load, ack_q, oe_q;
    logic [7:0] avs_address, want, fc_v;
    logic [31:0] avs_writedata, avs_readdata, bus_addr, bus_wdata, bus_rdata;
    logic [31:0] rd_q, lfsr_q, cnt, u, s_v, d_v, ra;
    logic [2:0] bus_size;
    logic [3:0] bus_fc;
    logic [1:0] transfer_request_n, transfer_ack_n, last_in, done_out, done_oe, slow, ss, ds;
    logic [10:0] ctrl, ctrl_v;
    integer errors, check_count, rd_bytes, wr_bytes, acks, dones, i, c, o, m;
    dma_two_channel i_dut (.clk, .rst_n, .ce(1'b1), .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .bus_request, .bus_grant, .bus_addr,
        .bus_rd, .bus_wr, .bus_size, .bus_fc, .bus_wdata, .bus_rdata, .bus_ack, .bus_berr,
        .transfer_request_n, .transfer_ack_n, .last_transfer_n_in(last_in),
        .last_transfer_n_out(done_out), .last_transfer_n_oe(done_oe));
    dma_partner i_partner (.clk, .rst_n, .bus_request, .bus_rd, .bus_wr, .bus_addr,
        .transfer_ack_n, .last_transfer_n_oe(done_oe), .slow, .berr_now, .steal, .load,
        .want, .bus_grant, .bus_ack, .bus_berr, .bus_rdata, .transfer_request_n,
        .last_transfer_n_in(last_in));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] nbytes(input logic [1:0] sz);
        nbytes = (sz == `SZ_BYTE) ? 1 : (sz == `SZ_WORD) ? 2 : 4;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic avs(input logic wr, input logic [7:0] a, input logic [31:0] d);
        integer n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk);
            n = n + 1;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd_q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        chk(n, 2);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        avs(1'b0, a, 32'h0000_0000);
        chk(rd_q, exp);
    endtask
    task automatic run(input logic ch, input logic [3:0] exp_st);
        integer k;
        lfsr_q = lfsr(lfsr_q);
        s_v = lfsr_q;
        lfsr_q = lfsr(lfsr_q);
        d_v = lfsr_q;
        fc_v = lfsr_q[15:8];
        ctrl_v = ctrl;
        rd_bytes = 0;
        wr_bytes = 0;
        acks = 0;
        dones = 0;
        avs(1'b1, {1'b0, ch, `REG_SRC}, s_v);
        avs(1'b1, {1'b0, ch, `REG_DST}, d_v);
        avs(1'b1, {1'b0, ch, `REG_CNT}, cnt);
        avs(1'b1, {1'b0, ch, `REG_FC}, {24'h00_0000, fc_v});
        avs(1'b1, {1'b0, ch, `REG_CTRL}, {21'h00_0000, ctrl});
        if (ctrl[2:1] != `REQ_INT) begin
            repeat (20) @(posedge clk);
            chk(bus_request, 1'b0);
            load <= 1'b1;
            @(posedge clk);
            load <= 1'b0;
        end
        k = 0;
        do begin
            avs(1'b0, {1'b0, ch, `REG_STAT}, 32'h0000_0000);
            k = k + 1;
        end while (rd_q[3:0] == 4'h0 && k < 400);
        chk(rd_q[3:0], exp_st);
        rd_chk({1'b0, ch, `REG_CTRL}, {21'h00_0000, ctrl[10:1], 1'b0});
        avs(1'b1, {1'b0, ch, `REG_STAT}, 32'h0000_000f);
        rd_chk({1'b0, ch, `REG_STAT}, 32'h0000_0000);
    endtask
    always @(posedge clk) begin
        ack_q <= transfer_ack_n[0];
        oe_q <= done_oe[0];
        if (ack_q && !transfer_ack_n[0])
            acks = acks + 1;
        if (oe_q && !done_oe[0])
            dones = dones + 1;
        if ((bus_rd || bus_wr) && (bus_ack || bus_berr)) begin
            if (bus_rd) begin
                rd_bytes = rd_bytes + bus_size;
                ra = bus_addr;
            end else begin
                wr_bytes = wr_bytes + bus_size;
                if (ctrl_v[8:4] == 5'h0a)
                    chk(bus_wdata, {16'h0000, ~ra[15:0]});
            end
            chk(bus_fc, bus_rd ? fc_v[3:0] : fc_v[7:4]);
            chk(!ctrl_v[4] && bus_size > `DUAL_PORT_BYTES, 1'b0);
        end
    end
    task tally_and_finish;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #(40 * 90000);
        errors = errors + 1;
        tally_and_finish;
    end
    initial begin
        errors = 0;
        check_count = 0;
        lfsr_q = 32'h2e3e_50bd;
        ack_q = 1'b1;
        oe_q = 1'b1;
        ctrl_v = 11'h000;
        fc_v = 8'h00;
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0000_0000;
        berr_now = 1'b0;
        steal = 1'b0;
        load = 1'b0;
        want = 8'h00;
        slow = 2'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (c = 0; c < 2; c = c + 1) begin
            for (o = 0; o < 24; o = o + 4)
                rd_chk(8'(64 * c + o), 32'h0000_0000);
            for (o = 8; o < 20; o = o + 4) begin
                lfsr_q = lfsr(lfsr_q);
                avs(1'b1, 8'(64 * c + o), lfsr_q);
                rd_chk(8'(64 * c + o), lfsr_q);
            end
        end
        avs(1'b1, 8'h80 | {2'b00, `REG_SRC}, 32'hffff_ffff);
        rd_chk(8'h80 | {2'b00, `REG_SRC}, 32'h0000_0000);
        for (i = 0; i < 9; i = i + 1) begin
            lfsr_q = lfsr(lfsr_q);
            ss = 2'(i % 3);
            ds = 2'(i / 3);
            u = nbytes(ss) > nbytes(ds) ? nbytes(ss) : nbytes(ds);
            cnt = u * (32'h0000_0001 + lfsr_q[1:0]);
            slow <= lfsr_q[3:2];
            ctrl = {lfsr_q[5:4], ds, ss, 2'b00, `REQ_INT, 1'b1};
            run(i[0], 4'h1);
            chk(rd_bytes, cnt);
            chk(wr_bytes, cnt);
            rd_chk({1'b0, i[0], `REG_CNT}, 32'h0000_0000);
            rd_chk({1'b0, i[0], `REG_SRC}, s_v + (ctrl[9] ? cnt : 32'h0000_0000));
            rd_chk({1'b0, i[0], `REG_DST}, d_v + (ctrl[10] ? cnt : 32'h0000_0000));
        end
        berr_now <= 1'b1;
        cnt = 32'h0000_0004;
        ctrl = {2'b01, `SZ_WORD, `SZ_WORD, 2'b00, `REQ_INT, 1'b1};
        run(1'b0, 4'h2);
        berr_now <= 1'b0;
        rd_chk({2'b00, `REG_SRC}, s_v + 32'h0000_0002);
        ctrl = {2'b00, 2'b00, 2'b00, 2'b10, `REQ_INT, 1'b1};
        run(1'b0, 4'h8);
        for (m = 0; m < 3; m = m + 1) begin
            steal <= (m == 1);
            want <= 8'(3 + m);
            slow <= 2'(m);
            cnt = 32'(6 + 2 * m);
            ctrl = {2'b11, `SZ_WORD, `SZ_WORD, (m == 2), 1'b1,
                (m == 1) ? `REQ_STEAL : `REQ_BURST, 1'b1};
            run(1'b0, 4'h1);
            chk(acks, 3 + m);
            chk(dones, 1);
            chk(rd_bytes, cnt);
            chk(wr_bytes, (m == 2) ? 0 : cnt);
        end
        tally_and_finish;
    end
endmodule // two_channel_dma_request_control_tb
